// file: nvm_unlock_cfg.svh
// offsets, bit positions, reset values and timing counts of the nvm control
//==========================================================================
// Summary of operation
// - broken unlock order is rejected
// - unlock key values are never stored
// - unlock key is write-only, reads zero
// - valid unlock plus start begins operation
// - fetch after start is discarded
// - core stalls until erase done, resumes
// - erase select turns write into erase
// - control bit order space..read start
// - address high top bit reads one
// - data high top two bits read zero
// - done flag sets regardless of enables
`ifndef NVM_UNLOCK_CFG_SVH
`define NVM_UNLOCK_CFG_SVH
`define OFF_CTRL 8'h00
`define OFF_KEY 8'h04
`define OFF_ADDR_LO 8'h08
`define OFF_ADDR_HI 8'h0c
`define OFF_DATA_LO 8'h10
`define OFF_DATA_HI 8'h14
`define OFF_FLAGS 8'h18
`define OFF_ENABLES 8'h1c
`define OFF_INTCTL 8'h20
`define BIT_PGD 7
`define BIT_CFG 6
`define BIT_LOAD_LATCHES_ONLY 5
`define BIT_ERASE 4
`define BIT_WERR 3
`define BIT_WRITE_ENABLE_BIT 2
`define BIT_WR 1
`define BIT_RD 0
`define BIT_DONE 4
`define BIT_GIE 7
`define KEY_FIRST 8'h55
`define KEY_SECOND 8'haa
`define CTRL_RESET 8'h00
`define ADDR_HI_FILL 1'b1
`define CLK_NS 4
`define ERASE_NS 2000
`define WRITE_NS 1000
`define ERASE_CYC ((`ERASE_NS + `CLK_NS - 1) / `CLK_NS)
`define WRITE_CYC ((`WRITE_NS + `CLK_NS - 1) / `CLK_NS)
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// file: nvm_unlock_pkg.sv
// types of the nvm unlock and erase control
package nvm_unlock_pkg;
  typedef enum logic [1:0] {UNL_IDLE, UNL_GOT_FIRST, UNL_ARMED} unlock_state_t;
  typedef logic [15:0] op_count_t;
endpackage : nvm_unlock_pkg

// file: nvm_unlock_erase_control.sv
// nvm self-programming control: unlock, erase/write timing, core stall
//
// Added by the designer: the AXI4-Lite interface to the registers and the register addresses.
`include "nvm_unlock_cfg.svh"
module nvm_unlock_erase_control
  import nvm_unlock_pkg::*;
(
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, active low
  input wire logic [31:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [31:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic cpu_stall, // core halted while operation runs
  output logic fetch_discard, // drop the fetched instruction
  output logic nvm_start, // operation start pulse
  output logic nvm_erase, // running operation is an erase
  output logic nvm_program_space, // operation targets program space
  output logic [14:0] nvm_row_address, // address of operation
  output logic [13:0] nvm_write_data, // data of a write
  output logic irq // level interrupt
);

  //==========================================================================
  // bus slave
  logic [7:0] ctrl;
  logic [7:0] addr_lo;
  logic [6:0] addr_hi;
  logic [7:0] data_lo;
  logic [5:0] data_hi;
  logic done_flag;
  logic done_enable;
  logic global_interrupt_enable;
  unlock_state_t unl;
  logic busy;
  logic done;
  op_count_t cnt;
  logic wr_fire;
  logic [7:0] wr_addr;
  logic [7:0] wr_byte;
  logic wr_hit;
  logic rd_fire;
  logic [7:0] rd_addr;
  logic [7:0] next_rdata;
  logic next_rhit;

  assign wr_fire = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
  assign wr_addr = s_axi_awaddr[7:0];
  assign wr_byte = s_axi_wdata[7:0];
  assign rd_fire = s_axi_arready && s_axi_arvalid;
  assign rd_addr = s_axi_araddr[7:0];

  function automatic logic addr_known(input logic [31:0] a);
    addr_known = (a[31:8] == 24'h00_0000) && (a[1:0] == 2'b00) &&
      (a[7:0] <= `OFF_INTCTL);
  endfunction : addr_known

  assign wr_hit = wr_fire && addr_known(s_axi_awaddr) && s_axi_wstrb[0];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready &&
        !s_axi_bvalid;
      s_axi_wready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready &&
        !s_axi_bvalid;
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_known(s_axi_awaddr) ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_comb
  begin
    next_rdata = 8'h00;
    next_rhit = 1'b1;
    unique case (rd_addr)
      `OFF_CTRL: next_rdata = ctrl;
      `OFF_KEY: next_rdata = 8'h00;
      `OFF_ADDR_LO: next_rdata = addr_lo;
      `OFF_ADDR_HI: next_rdata = {`ADDR_HI_FILL, addr_hi};
      `OFF_DATA_LO: next_rdata = data_lo;
      `OFF_DATA_HI: next_rdata = {2'b00, data_hi};
      `OFF_FLAGS: next_rdata = 8'(done_flag) << `BIT_DONE;
      `OFF_ENABLES: next_rdata = 8'(done_enable) << `BIT_DONE;
      `OFF_INTCTL: next_rdata = 8'(global_interrupt_enable) << `BIT_GIE;
      default: next_rhit = 1'b0;
    endcase
    if (!addr_known(s_axi_araddr))
      next_rhit = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (rd_fire)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= next_rhit ? {24'h00_0000, next_rdata} : 32'h0000_0000;
        s_axi_rresp <= next_rhit ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  //==========================================================================
  // unlock sequence
  logic start_req, start_ok;

  assign start_req = wr_hit && wr_addr == `OFF_CTRL && wr_byte[`BIT_WR] &&
    !busy;
  assign start_ok = start_req && unl == UNL_ARMED && ctrl[`BIT_WRITE_ENABLE_BIT];

  // key values only move the tracker, nothing is stored
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      unl <= UNL_IDLE;
    else if (wr_hit && wr_addr == `OFF_KEY)
    begin
      unique case (unl)
        UNL_IDLE: unl <= (wr_byte == `KEY_FIRST) ? UNL_GOT_FIRST : UNL_IDLE;
        UNL_GOT_FIRST:
          unl <= (wr_byte == `KEY_SECOND) ? UNL_ARMED : UNL_IDLE;
        UNL_ARMED: unl <= UNL_IDLE;
      endcase
    end
    else if (wr_hit)
      unl <= UNL_IDLE;
  end

  //==========================================================================
  // control, address and data registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctrl <= `CTRL_RESET;
    else
    begin
      if (wr_hit && wr_addr == `OFF_CTRL)
      begin
        ctrl[7:2] <= wr_byte[7:2];
        ctrl[`BIT_RD] <= wr_byte[`BIT_RD];
      end
      else
        ctrl[`BIT_RD] <= 1'b0;
      if (start_req && !start_ok)
        ctrl[`BIT_WERR] <= 1'b1;
      if (start_ok)
        ctrl[`BIT_WR] <= 1'b1;
      else if (done)
        ctrl[`BIT_WR] <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      addr_lo <= 8'h00;
      addr_hi <= 7'h00;
      data_lo <= 8'h00;
      data_hi <= 6'h00;
    end
    else if (wr_hit && !busy)
    begin
      if (wr_addr == `OFF_ADDR_LO)
        addr_lo <= wr_byte;
      if (wr_addr == `OFF_ADDR_HI)
        addr_hi <= wr_byte[6:0];
      if (wr_addr == `OFF_DATA_LO)
        data_lo <= wr_byte;
      if (wr_addr == `OFF_DATA_HI)
        data_hi <= wr_byte[5:0];
    end
  end

  //==========================================================================
  // operation timing and core stall
  assign done = busy && cnt == 16'h0000;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      busy <= 1'b0;
      cnt <= 16'h0000;
      nvm_start <= 1'b0;
      fetch_discard <= 1'b0;
      nvm_erase <= 1'b0;
      nvm_program_space <= 1'b0;
      nvm_row_address <= 15'h0000;
      nvm_write_data <= 14'h0000;
    end
    else
    begin
      nvm_start <= start_ok;
      fetch_discard <= start_ok;
      if (start_ok)
      begin
        busy <= 1'b1;
        nvm_erase <= wr_byte[`BIT_ERASE];
        cnt <= wr_byte[`BIT_ERASE] ? op_count_t'(`ERASE_CYC - 1) :
          op_count_t'(`WRITE_CYC - 1);
        nvm_program_space <= wr_byte[`BIT_PGD];
        nvm_row_address <= {addr_hi, addr_lo};
        nvm_write_data <= {data_hi, data_lo};
      end
      else if (done)
        busy <= 1'b0;
      else if (busy)
        cnt <= cnt - 16'h0001;
    end
  end

  assign cpu_stall = busy;

  //==========================================================================
  // completion flag and interrupt
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      done_flag <= 1'b0;
      done_enable <= 1'b0;
      global_interrupt_enable <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      if (done)
        done_flag <= 1'b1;
      else if (wr_hit && wr_addr == `OFF_FLAGS && wr_byte[`BIT_DONE])
        done_flag <= 1'b0;
      if (wr_hit && wr_addr == `OFF_ENABLES)
        done_enable <= wr_byte[`BIT_DONE];
      if (wr_hit && wr_addr == `OFF_INTCTL)
        global_interrupt_enable <= wr_byte[`BIT_GIE];
      irq <= (done_flag || done) && done_enable;
    end
  end

  //==========================================================================
  // checks
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic [7:0] last_rd;
  op_count_t stall_len;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      last_rd <= 8'h00;
      stall_len <= 16'h0000;
    end
    else
    begin
      if (rd_fire)
        last_rd <= rd_addr;
      stall_len <= start_ok ? 16'h0000 : stall_len + 16'(busy);
    end
  end

  sequence s_armed_start;
    unl == UNL_ARMED && start_req && ctrl[`BIT_WRITE_ENABLE_BIT];
  endsequence
  sequence s_op_begins;
    nvm_start && fetch_discard && cpu_stall;
  endsequence

  chk_key_reads_zero: assert property (
    $rose(s_axi_rvalid) && last_rd == `OFF_KEY |-> s_axi_rdata == 0)
    else $error("unlock key read not zero");
  chk_addr_high_top: assert property (
    $rose(s_axi_rvalid) && last_rd == `OFF_ADDR_HI |-> s_axi_rdata[7])
    else $error("address high top bit not one");
  chk_data_high_top: assert property (
    $rose(s_axi_rvalid) && last_rd == `OFF_DATA_HI |->
      s_axi_rdata[7:6] == 2'b00)
    else $error("data high top bits not zero");
  chk_start_begins: assert property (
    s_armed_start |=> s_op_begins ##1 !nvm_start && !fetch_discard)
    else $error("armed start did not begin operation");
  chk_no_start_unlocked: assert property (
    start_req && (unl != UNL_ARMED || !ctrl[`BIT_WRITE_ENABLE_BIT]) |=>
      !nvm_start && ctrl[`BIT_WERR])
    else $error("start taken without unlock");
  chk_break_rejects: assert property (
    unl == UNL_GOT_FIRST && wr_hit && wr_addr != `OFF_KEY |=> unl == UNL_IDLE)
    else $error("broken unlock order not rejected");
  chk_erase_select: assert property (
    start_ok |=> nvm_erase == $past(wr_byte[`BIT_ERASE]))
    else $error("erase select not applied");
  chk_stall_length: assert property (
    $fell(cpu_stall) |->
      stall_len == op_count_t'(nvm_erase ? `ERASE_CYC : `WRITE_CYC))
    else $error("stall length wrong");
  chk_flag_on_done: assert property (
    done |=> done_flag && !cpu_stall && !ctrl[`BIT_WR])
    else $error("completion flag not set");
  chk_discard_once: assert property (
    fetch_discard |-> $past(start_ok) ##1 !fetch_discard [*2])
    else $error("discard pulse wrong");

endmodule : nvm_unlock_erase_control

// file: nvm_unlock_erase_control_tb.sv
// self-checking testbench of the nvm unlock and erase control
`include "nvm_unlock_cfg.svh"
module nvm_unlock_erase_control_tb import nvm_unlock_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  //==========================================================================
  // signals and device
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, cpu_stall, fetch_discard, nvm_start, nvm_erase;
  logic nvm_program_space, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rd, rng = 32'h0000_bb93;
  logic [14:0] nvm_row_address;
  logic [13:0] nvm_write_data;
  logic st, fd, er, sl;
  logic [7:0] last [4];
  logic [7:0] offs [4] = '{`OFF_ADDR_LO, `OFF_ADDR_HI, `OFF_DATA_LO,
    `OFF_DATA_HI};
  int n_errors = 0, n_checks = 0, n;
  nvm_unlock_erase_control u_dut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_stall, .fetch_discard,
    .nvm_start, .nvm_erase, .nvm_program_space, .nvm_row_address,
    .nvm_write_data, .irq);
  initial
  begin
    forever #2 aclk = ~aclk;
  end
  //==========================================================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  function automatic logic [31:0] expv(input logic [7:0] a, d);
    if (a == `OFF_ADDR_HI)
      return {24'h00_0000, `ADDR_HI_FILL, d[6:0]};
    if (a == `OFF_DATA_HI)
      return {24'h00_0000, 2'b00, d[5:0]};
    return {24'h00_0000, d};
  endfunction : expv
  task automatic results;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic pick(input int w);
    return w == 0 ? s_axi_awready : w == 1 ? s_axi_bvalid :
      w == 2 ? s_axi_arready : s_axi_rvalid;
  endfunction : pick
  task automatic waitfor(input int w);
    int i;
    i = 0;
    do
    begin
      @(negedge aclk);
      i++;
    end
    while (pick(w) !== 1'b1 && i < 100);
    if (pick(w) !== 1'b1)
    begin
      n_errors++;
      $display("BAD %0t: wait ran out", $time);
      results();
    end
  endtask : waitfor
  //==========================================================================
  // bus cycles
  task automatic wr(input logic [7:0] a, d);
    @(posedge aclk);
    s_axi_awaddr <= 32'(a);
    s_axi_wdata <= 32'(d);
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    waitfor(0);
    @(posedge aclk);
    s_axi_awvalid <= 0;
    s_axi_wvalid <= 0;
    waitfor(1);
    {resp, st, fd, er, sl} = {s_axi_bresp, nvm_start, fetch_discard,
      nvm_erase, cpu_stall};
    @(posedge aclk);
    s_axi_bready <= 0;
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= 32'(a);
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    waitfor(2);
    @(posedge aclk);
    s_axi_arvalid <= 0;
    waitfor(3);
    {rd, resp} = {s_axi_rdata, s_axi_rresp};
    @(posedge aclk);
    s_axi_rready <= 0;
  endtask : rdr
  task automatic seq(input logic [7:0] k1, k2, c, input logic mid);
    wr(`OFF_CTRL, c & 8'hfd);
    wr(`OFF_KEY, k1);
    if (mid)
      wr(`OFF_ENABLES, 8'h10);
    wr(`OFF_KEY, k2);
    wr(`OFF_CTRL, c);
  endtask : seq
  task automatic run_op(input int cyc, input logic ers, pgm);
    chk({st, fd, er, sl}, {3'b111 & {2'b11, ers}, 1'b1});
    n = 0;
    do
    begin
      @(negedge aclk);
      n++;
    end
    while (cpu_stall === 1'b1 && n < 2000);
    chk(n, cyc);
    if (cpu_stall === 1'b1)
      results();
    chk(nvm_program_space, pgm);
    chk(nvm_row_address, {last[1][6:0], last[0]});
    chk(nvm_write_data, {last[3][5:0], last[2]});
    rdr(`OFF_FLAGS);
    chk(rd[`BIT_DONE], 1'b1);
  endtask : run_op
  //==========================================================================
  // main sequence
  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    for (int j = 0; j < 4; j++)
    begin
      rdr(offs[j]);
      chk(rd, expv(offs[j], 8'h00));
    end
    rdr(`OFF_CTRL);
    chk(rd, 32'(`CTRL_RESET));
    for (int k = 0; k < 6; k++)
      for (int j = 0; j < 4; j++)
      begin
        rng = xs(rng);
        last[j] = (k == 0) ? 8'hff : rng[7:0];
        wr(offs[j], last[j]);
        rdr(offs[j]);
        chk(rd, expv(offs[j], last[j]));
      end
    wr(`OFF_KEY, 8'h55);
    rdr(`OFF_KEY);
    chk(rd, 32'h0000_0000);
    wr(8'h24, 8'hff);
    chk(resp, `RESP_SLVERR);
    rdr(8'h02);
    chk({resp, rd}, {`RESP_SLVERR, 32'h0000_0000});
    wr(`OFF_INTCTL, 8'h00);
    wr(`OFF_FLAGS, 8'h10);
    wr(`OFF_ENABLES, 8'h10);
    seq(8'h55, 8'haa, 8'h12, 0);
    chk(st, 1'b0);
    rdr(`OFF_CTRL);
    chk(rd[`BIT_WERR], 1'b1);
    seq(8'haa, 8'h55, 8'h16, 0);
    chk(st, 1'b0);
    seq(8'h55, 8'haa, 8'h16, 1);
    chk(st, 1'b0);
    seq(8'h55, 8'h55, 8'h16, 0);
    chk(st, 1'b0);
    seq(8'h55, 8'haa, 8'h16, 0);
    run_op(`ERASE_CYC, 1, 0);
    @(negedge aclk);
    chk(irq, 1'b1);
    wr(`OFF_FLAGS, 8'h10);
    @(negedge aclk);
    chk(irq, 1'b0);
    wr(`OFF_ENABLES, 8'h00);
    seq(8'h55, 8'haa, 8'h86, 0);
    run_op(`WRITE_CYC, 0, 1);
    chk(irq, 1'b0);
    rdr(`OFF_CTRL);
    chk(rd[`BIT_WR], 1'b0);
    wr(`OFF_CTRL, 8'h80);
    wr(`OFF_INTCTL, 8'h80);
    results();
  end
endmodule : nvm_unlock_erase_control_tb
